// ===== rtl/bridge_win_pkg.sv
`default_nettype none
package bridge_win_pkg;
    // Dword offsets in configuration space
    localparam logic [7:0] OFF_IO_SECSTAT  = 8'h1c;
    localparam logic [7:0] OFF_MEM_WIN     = 8'h20;
    localparam logic [7:0] OFF_PF_WIN      = 8'h24;
    localparam logic [7:0] OFF_PF_BASE_UP  = 8'h28;
    localparam logic [7:0] OFF_PF_LIMIT_UP = 8'h2c;

    // Secondary status bit positions, within the dword, and the command parity enable bit
    localparam int BIT_66MHZ   = 21;
    localparam int BIT_FB2B    = 23;
    localparam int BIT_DPERR   = 24;
    localparam int BIT_DEVSEL  = 25;
    localparam int BIT_STA     = 27;
    localparam int BIT_RTA     = 28;
    localparam int BIT_RMA     = 29;
    localparam int BIT_RSERR   = 30;
    localparam int BIT_DETPERR = 31;
    localparam int CMD_PERR_EN = 6;

    localparam logic       RST_66MHZ  = 1'b1;
    localparam logic       RST_FB2B   = 1'b0;
    localparam logic [1:0] RST_DEVSEL = 2'h1;
    localparam logic [3:0] ADDR_CAP_32 = 4'h0;
    localparam logic [3:0] ADDR_CAP_64 = 4'h1;
    localparam logic [3:0] RST_ADDR_CAP = ADDR_CAP_64;
    localparam logic [11:0] RST_WIN_FIELD = 12'h000;
    localparam logic [31:0] RST_UPPER     = 32'h0000_0000;

    // Base and limit field positions
    localparam int BASE_LSB  = 4;
    localparam int LIMIT_LSB = 20;
    localparam int WIN_W     = 12;
    localparam logic [19:0] LOW_ZERO = 20'h0_0000;
    localparam logic [19:0] LOW_ONES = 20'hf_ffff;

    // Config access request
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    // Secondary bus events, one-cycle pulses from the bus logic
    typedef struct packed {
        logic tgt_abort_sent;
        logic tgt_abort_rcvd;
        logic mst_abort_rcvd;
        logic addr_perr;
        logic data_perr;
    } sec_evt_t;
endpackage
`default_nettype wire

// ===== rtl/bridge_secondary_status_and_windows.sv
// Contract
// R1 - 66 MHz capable status bit is read-only and reads one.
// R2 - Fast back-to-back capable status bit is read-only and reads zero.
// R3 - Data parity flag sets on parity error pin with command bit 6 set.
// R4 - DEVSEL timing field read-only, reads 01 medium.
// R5 - Signaled target abort flag sets on our target abort; write one clears.
// R6 - Received target abort flag sets when our transaction target-aborts.
// R7 - Received master abort flag sets when our transaction master-aborts.
// R8 - Received system error flag sets on either system error pin.
// R9 - Detected parity flag sets on secondary address or data parity error.
// R10 - Low four bits of memory base and limit read zero.
// R11 - Memory base gives window bottom bits 31:20, low bits zero.
// R12 - Memory limit gives window top bits 31:20, low bits ones.
// R13 - Memory window decides forwarding of memory transactions.
// R14 - Prefetchable capability fields read-only, read 0001 for 64-bit.
// R15 - Prefetchable base gives bottom bits 31:20, low bits zero.
// R16 - Prefetchable limit gives top bits 31:20, low bits ones.
// R17 - Reserved secondary status bits read zero.
// R18 - Window hit is inclusive at both base and limit.
// R19 - Writing zero keeps flags; a set event beats a same-cycle clear.
// R20 - Upper prefetchable base register supplies bits 63:32, resets zero.
`default_nettype none
module bridge_secondary_status_and_windows
    import bridge_win_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Configuration access
    input  wire bridge_win_pkg::cfg_req_t cfg_req_i,
    input  wire logic                    cfg_valid_i,
    input  wire logic [15:0]             command_i,
    output logic [31:0]                  cfg_rdata_o,
    output logic                         cfg_ack_o,
    // Secondary bus pins, asynchronous
    input  wire logic                    first_downstream_parity_err_n,
    input  wire logic                    second_downstream_parity_err_n,
    input  wire logic                    first_downstream_system_err_n,
    input  wire logic                    second_downstream_system_err_n,
    // Secondary bus events from bridge logic
    input  wire bridge_win_pkg::sec_evt_t sec_evt_i,
    // Forwarding decode
    input  wire logic [63:0]             fwd_addr_i,
    output logic                         mem_hit_o,
    output logic                         pf_hit_o
);
    import bridge_win_pkg::*;

    // Pin synchronisers: two stages before use
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [3:0] pin_s1_d;
    logic [3:0] pin_s2_d;

    always_comb
    begin
        pin_s1_d = {~first_downstream_parity_err_n,
                    ~second_downstream_parity_err_n,
                    ~first_downstream_system_err_n,
                    ~second_downstream_system_err_n};
        pin_s2_d = pin_s1_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end
        else
        begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end

    // Register state
    logic        dperr_q, sta_q, rta_q, rma_q, rserr_q, detperr_q;
    logic        dperr_d, sta_d, rta_d, rma_d, rserr_d, detperr_d;
    logic [11:0] mem_base_q, mem_limit_q, pf_base_q, pf_limit_q;
    logic [11:0] mem_base_d, mem_limit_d, pf_base_d, pf_limit_d;
    logic [31:0] pf_base_up_q, pf_limit_up_q;
    logic [31:0] pf_base_up_d, pf_limit_up_d;
    logic [31:0] rdata_d;
    logic        ack_d;
    logic        mem_hit_d, pf_hit_d;

    // Byte-lane masked write data
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Sticky flag: set beats write-one clear
    function automatic logic w1c(input logic cur, input logic set,
                                 input logic clr);
        w1c = set | (cur & ~clr);                           // see R19
    endfunction

    // Merge writable bits under byte enables
    function automatic logic [11:0] upd12(input logic [11:0] cur,
                                          input logic [11:0] wv,
                                          input logic [11:0] m);
        upd12 = (wv & m) | (cur & ~m);
    endfunction

    logic        wr_stat, wr_mem, wr_pf, wr_bup, wr_lup, rd_any;
    logic [31:0] wm, wclr;
    logic        perr_pin, serr_pin;

    always_comb
    begin
        wr_stat = 1'b0;
        wr_mem  = 1'b0;
        wr_pf   = 1'b0;
        wr_bup  = 1'b0;
        wr_lup  = 1'b0;
        rd_any  = cfg_valid_i & ~cfg_req_i.wr;
        wm      = lane_mask(cfg_req_i.be);
        wclr    = cfg_req_i.wdata & wm;
        if (cfg_valid_i && cfg_req_i.wr)
        begin
            if (cfg_req_i.addr == OFF_IO_SECSTAT)
                wr_stat = 1'b1;
            else if (cfg_req_i.addr == OFF_MEM_WIN)
                wr_mem = 1'b1;
            else if (cfg_req_i.addr == OFF_PF_WIN)
                wr_pf = 1'b1;
            else if (cfg_req_i.addr == OFF_PF_BASE_UP)
                wr_bup = 1'b1;
            else if (cfg_req_i.addr == OFF_PF_LIMIT_UP)
                wr_lup = 1'b1;
        end
        if (!wr_stat)
            wclr = 32'h0000_0000;

        perr_pin = pin_s2_q[3] | pin_s2_q[2];
        serr_pin = pin_s2_q[1] | pin_s2_q[0];

        dperr_d   = w1c(dperr_q, perr_pin & command_i[CMD_PERR_EN],
                        wclr[BIT_DPERR]);                   // see R3
        sta_d     = w1c(sta_q, sec_evt_i.tgt_abort_sent,
                        wclr[BIT_STA]);                     // see R5
        rta_d     = w1c(rta_q, sec_evt_i.tgt_abort_rcvd,
                        wclr[BIT_RTA]);                     // see R6
        rma_d     = w1c(rma_q, sec_evt_i.mst_abort_rcvd,
                        wclr[BIT_RMA]);                     // see R7
        rserr_d   = w1c(rserr_q, serr_pin, wclr[BIT_RSERR]); // see R8
        detperr_d = w1c(detperr_q,
                        sec_evt_i.addr_perr | sec_evt_i.data_perr,
                        wclr[BIT_DETPERR]);                 // see R9

        mem_base_d  = mem_base_q;
        mem_limit_d = mem_limit_q;
        pf_base_d   = pf_base_q;
        pf_limit_d  = pf_limit_q;
        if (wr_mem)
        begin
            mem_base_d  = upd12(mem_base_q, cfg_req_i.wdata[15:4],
                                wm[15:4]);                  // see R11
            mem_limit_d = upd12(mem_limit_q, cfg_req_i.wdata[31:20],
                                wm[31:20]);                 // see R12
        end
        if (wr_pf)
        begin
            pf_base_d  = upd12(pf_base_q, cfg_req_i.wdata[15:4],
                               wm[15:4]);                   // see R15
            pf_limit_d = upd12(pf_limit_q, cfg_req_i.wdata[31:20],
                               wm[31:20]);                  // see R16
        end
        pf_base_up_d  = wr_bup ? ((cfg_req_i.wdata & wm)
                        | (pf_base_up_q & ~wm)) : pf_base_up_q; // see R20
        pf_limit_up_d = wr_lup ? ((cfg_req_i.wdata & wm)
                        | (pf_limit_up_q & ~wm)) : pf_limit_up_q;

        // Read data; unmapped offsets read zero
        rdata_d = 32'h0000_0000;
        if (cfg_req_i.addr == OFF_IO_SECSTAT)
        begin
            rdata_d[BIT_66MHZ]              = RST_66MHZ;   // see R1
            rdata_d[BIT_FB2B]               = RST_FB2B;    // see R2
            rdata_d[BIT_DEVSEL +: 2]        = RST_DEVSEL;  // see R4
            rdata_d[BIT_DPERR]              = dperr_q;
            rdata_d[BIT_STA]                = sta_q;
            rdata_d[BIT_RTA]                = rta_q;
            rdata_d[BIT_RMA]                = rma_q;
            rdata_d[BIT_RSERR]              = rserr_q;
            rdata_d[BIT_DETPERR]            = detperr_q;
            // Bits 20:16 and 22 stay zero; see R17
        end
        else if (cfg_req_i.addr == OFF_MEM_WIN)
        begin
            // Low nibbles stay zero; see R10
            rdata_d[BASE_LSB +: WIN_W]  = mem_base_q;
            rdata_d[LIMIT_LSB +: WIN_W] = mem_limit_q;
        end
        else if (cfg_req_i.addr == OFF_PF_WIN)
        begin
            rdata_d[3:0]                = RST_ADDR_CAP;    // see R14
            rdata_d[BASE_LSB +: WIN_W]  = pf_base_q;
            rdata_d[19:16]              = RST_ADDR_CAP;    // see R14
            rdata_d[LIMIT_LSB +: WIN_W] = pf_limit_q;
        end
        else if (cfg_req_i.addr == OFF_PF_BASE_UP)
            rdata_d = pf_base_up_q;
        else if (cfg_req_i.addr == OFF_PF_LIMIT_UP)
            rdata_d = pf_limit_up_q;
        if (!rd_any)
            rdata_d = 32'h0000_0000;
        ack_d = cfg_valid_i;

        // Inclusive window compare
        mem_hit_d = (fwd_addr_i[63:32] == 32'h0000_0000)
            && (fwd_addr_i[31:0] >= {mem_base_q, LOW_ZERO})
            && (fwd_addr_i[31:0] <= {mem_limit_q, LOW_ONES}); // see R13
        pf_hit_d = (fwd_addr_i >= {pf_base_up_q, pf_base_q, LOW_ZERO})
            && (fwd_addr_i <= {pf_limit_up_q, pf_limit_q, LOW_ONES});
                                                       // see R16 see R18
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dperr_q       <= 1'b0;
            sta_q         <= 1'b0;
            rta_q         <= 1'b0;
            rma_q         <= 1'b0;
            rserr_q       <= 1'b0;
            detperr_q     <= 1'b0;
            mem_base_q    <= RST_WIN_FIELD;
            mem_limit_q   <= RST_WIN_FIELD;
            pf_base_q     <= RST_WIN_FIELD;
            pf_limit_q    <= RST_WIN_FIELD;
            pf_base_up_q  <= RST_UPPER;
            pf_limit_up_q <= RST_UPPER;
            cfg_rdata_o   <= 32'h0000_0000;
            cfg_ack_o     <= 1'b0;
            mem_hit_o     <= 1'b0;
            pf_hit_o      <= 1'b0;
        end
        else
        begin
            dperr_q       <= dperr_d;
            sta_q         <= sta_d;
            rta_q         <= rta_d;
            rma_q         <= rma_d;
            rserr_q       <= rserr_d;
            detperr_q     <= detperr_d;
            mem_base_q    <= mem_base_d;
            mem_limit_q   <= mem_limit_d;
            pf_base_q     <= pf_base_d;
            pf_limit_q    <= pf_limit_d;
            pf_base_up_q  <= pf_base_up_d;
            pf_limit_up_q <= pf_limit_up_d;
            cfg_rdata_o   <= rdata_d;
            cfg_ack_o     <= ack_d;
            mem_hit_o     <= mem_hit_d;
            pf_hit_o      <= pf_hit_d;
        end
    end
endmodule
`default_nettype wire

// ===== bench/bridge_win_monitor.sv
`default_nettype none
module bridge_win_monitor
    import bridge_win_pkg::*;
(
    // Clock and reset
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    // Config access and events
    input wire bridge_win_pkg::cfg_req_t cfg_req_i,
    input wire logic                     cfg_valid_i,
    input wire logic [31:0]              cfg_rdata_o,
    input wire logic                     cfg_ack_o,
    input wire bridge_win_pkg::sec_evt_t sec_evt_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence rd_at(logic [7:0] a);
        cfg_valid_i && !cfg_req_i.wr && cfg_req_i.addr == a;
    endsequence
    sequence sta_then_rd;
        sec_evt_i.tgt_abort_sent ##[1:3] rd_at(8'h1c);
    endsequence
    sequence rta_then_rd;
        sec_evt_i.tgt_abort_rcvd ##[1:3] rd_at(8'h1c);
    endsequence

    a_ack_timing: assert property (cfg_ack_o == $past(cfg_valid_i))
        else $error("ack not one cycle after strobe");
    a_cap_66mhz: assert property (rd_at(8'h1c) |=> cfg_rdata_o[21])
        else $error("66 MHz bit not one");
    a_fast_b2b_zero: assert property (
        rd_at(8'h1c) |=> !cfg_rdata_o[23])
        else $error("fast back-to-back bit not zero");
    a_devsel_medium: assert property (
        rd_at(8'h1c) |=> cfg_rdata_o[26:25] == 2'h1)
        else $error("devsel timing not medium");
    a_reserved_zero: assert property (
        rd_at(8'h1c) |=> !cfg_rdata_o[22] && cfg_rdata_o[20:0] == 21'h0)
        else $error("reserved status bits not zero");
    a_mem_low_zero: assert property (
        rd_at(8'h20) |=> cfg_rdata_o[3:0] == 4'h0
            && cfg_rdata_o[19:16] == 4'h0)
        else $error("memory window low bits not zero");
    a_pf_cap_64: assert property (
        rd_at(8'h24) |=> cfg_rdata_o[3:0] == 4'h1
            && cfg_rdata_o[19:16] == 4'h1)
        else $error("prefetch capability not 64-bit");
    a_sta_seen: assert property (sta_then_rd |=> cfg_rdata_o[27])
        else $error("signaled target abort flag not set");
    a_rta_seen: assert property (rta_then_rd |=> cfg_rdata_o[28])
        else $error("received target abort flag not set");
endmodule

bind bridge_secondary_status_and_windows bridge_win_monitor
    bridge_win_monitor_inst (.clk_i, .rst_i, .cfg_req_i, .cfg_valid_i,
    .cfg_rdata_o, .cfg_ack_o, .sec_evt_i);
`default_nettype wire

// ===== bench/sec_bus_agents.sv
`default_nettype none
module sec_bus_agents
    import bridge_win_pkg::*;
(
    input  wire logic                     clk_i,
    // Parity 0/1 and system error 2/3, pulled up when idle
    output var logic [3:0]                pins_n_o,
    output var bridge_win_pkg::sec_evt_t  evt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        pins_n_o = 4'hf;
        evt_o = '0;
    end
    // One-cycle event pulse
    task automatic pulse(input sec_evt_t e);
        @(posedge clk_i);
        evt_o <= e;
        @(posedge clk_i);
        evt_o <= '0;
    endtask
    // Pin held low two cycles, long enough to pass the synchroniser
    task automatic drop(input int k);
        @(posedge clk_i);
        pins_n_o[k] <= 1'b0;
        repeat (2) @(posedge clk_i);
        pins_n_o[k] <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bridge_win_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cfg_valid_i = 1'b0;
    cfg_req_t    cfg_req_i = '0;
    logic [15:0] command_i = 16'h0;
    logic [63:0] fwd_addr_i = 64'h0;
    logic [31:0] cfg_rdata_o, rd;
    logic        cfg_ack_o, mem_hit_o, pf_hit_o;
    logic [3:0]  pins_n;
    sec_evt_t    sec_evt;
    int          error_cnt = 0;
    int          check_count = 0;

    bridge_secondary_status_and_windows
        bridge_secondary_status_and_windows_inst (
        .clk_i, .rst_i, .cfg_req_i, .cfg_valid_i, .command_i, .cfg_rdata_o,
        .cfg_ack_o, .first_downstream_parity_err_n(pins_n[0]),
        .second_downstream_parity_err_n(pins_n[1]),
        .first_downstream_system_err_n(pins_n[2]),
        .second_downstream_system_err_n(pins_n[3]), .sec_evt_i(sec_evt),
        .fwd_addr_i, .mem_hit_o, .pf_hit_o);
    sec_bus_agents sec_bus_agents_inst (.clk_i, .pins_n_o(pins_n),
        .evt_o(sec_evt));

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d,
                       logic [3:0] b = 4'hf);
        @(posedge clk_i);
        cfg_req_i <= '{w, a, b, d};
        cfg_valid_i <= 1'b1;
        @(posedge clk_i);
        cfg_valid_i <= 1'b0;
        #1 chk("ack", 32'h1, {31'h0, cfg_ack_o});
        rd = cfg_rdata_o;
    endtask
    task automatic rd_chk(logic [7:0] a, logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk("rdata", e, rd);
    endtask
    task automatic hit(logic [63:0] a, logic m, logic p);
        @(posedge clk_i);
        fwd_addr_i <= a;
        @(posedge clk_i);
        #1 chk("mem_hit", {31'h0, m}, {31'h0, mem_hit_o});
        chk("pf_hit", {31'h0, p}, {31'h0, pf_hit_o});
    endtask

    task automatic t_reset_vals();
        rd_chk(8'h1c, 32'h0220_0000);
        acc(1'b1, 8'h1c, 32'hffff_ffff);
        rd_chk(8'h1c, 32'h0220_0000);
        rd_chk(8'h20, 32'h0);
        rd_chk(8'h24, 32'h0001_0001);
        rd_chk(8'h28, 32'h0);
        acc(1'b1, 8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
    endtask
    task automatic t_flags();
        int fbit[5] = '{31, 31, 29, 28, 27};
        logic [31:0] fexp;
        for (int i = 0; i < 5; i++)
        begin
            fexp = 32'h0220_0000 | (32'h1 << fbit[i]);
            sec_bus_agents_inst.pulse(sec_evt_t'(5'h1 << i));
            rd_chk(8'h1c, fexp);
            acc(1'b1, 8'h1c, 32'h0);
            rd_chk(8'h1c, fexp);
            acc(1'b1, 8'h1c, 32'h1 << fbit[i]);
            rd_chk(8'h1c, 32'h0220_0000);
        end
        fork
            sec_bus_agents_inst.pulse(sec_evt_t'(5'h10));
            acc(1'b1, 8'h1c, 32'h0800_0000);
        join
        rd_chk(8'h1c, 32'h0a20_0000);
        acc(1'b1, 8'h1c, 32'h0800_0000);
    endtask
    task automatic t_pins();
        logic [31:0] pexp[5] = '{32'h0100_0000, 32'h0100_0000,
                                 32'h4000_0000, 32'h4000_0000, 32'h0};
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk_i);
            command_i <= (k < 2) ? 16'h0040 : 16'h0000;
            sec_bus_agents_inst.drop(k % 4);
            repeat (3) @(posedge clk_i);
            rd_chk(8'h1c, 32'h0220_0000 | pexp[k]);
            acc(1'b1, 8'h1c, pexp[k]);
        end
    endtask
    task automatic t_windows();
        acc(1'b1, 8'h20, 32'h124f_123f);
        rd_chk(8'h20, 32'h1240_1230);
        hit(64'h1230_0000, 1'b1, 1'b0);
        hit(64'h122f_ffff, 1'b0, 1'b0);
        hit(64'h124f_ffff, 1'b1, 1'b0);
        hit(64'h1250_0000, 1'b0, 1'b0);
        hit(64'h1_1230_0000, 1'b0, 1'b0);
        acc(1'b1, 8'h24, 32'h002f_001f);
        rd_chk(8'h24, 32'h0021_0011);
        acc(1'b1, 8'h28, 32'h1);
        acc(1'b1, 8'h2c, 32'h1);
        rd_chk(8'h28, 32'h1);
        rd_chk(8'h2c, 32'h1);
        hit(64'h1_0010_0000, 1'b0, 1'b1);
        hit(64'h1_000f_ffff, 1'b0, 1'b0);
        hit(64'h1_002f_ffff, 1'b0, 1'b1);
        hit(64'h1_0030_0000, 1'b0, 1'b0);
        acc(1'b1, 8'h20, 32'h0000_0000, 4'hc);
        rd_chk(8'h20, 32'h0000_1230);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_vals();
        t_flags();
        t_pins();
        t_windows();
        report_and_stop();
    end
endmodule
`default_nettype wire
